// ==== rtl/keypad_defs.vh ====
// Functional notes
// - Eight maskable inputs share one request
// - Inputs 0-3 port_a, 4-7 port_d
// - Pin enable selects pin, enables pull-up
// - Latch when enabled pin falls, all high
// - Edge mode ignores fall while another low
// - Level mode holds request while pin low
// - Level mode clears after ack and release
// - Vector fetch acknowledge equals software acknowledge
// - Ack bit write one clears, reads zero
// - Edge after acknowledge latches new request
// - Edge mode acknowledge clears immediately
// - Reset clears latch and sensitivity select
// - Pending flag shows latch regardless of mask
// - Mask withholds request; vector FFDF/FFDE
// - Sensitivity select: 1 level+edge, 0 edge
// - Pin enable forces input over direction
// - Pin enable register read/write, reset clears
// - Active in wait; unmasked request wakes
// - Active in stop; unmasked request wakes
// - Break with clear-enable 0 blocks software acknowledge; vector fetch still clears
// - Break with clear-enable 1 allows clear
`ifndef KEYPAD_DEFS_VH
`define KEYPAD_DEFS_VH
`define KP_STATUS_CONTROL_ADDR 12'h000
`define KP_PIN_ENABLE_ADDR     12'h004
`define KP_BIT_PENDING         3
`define KP_BIT_ACK             2
`define KP_BIT_MASK            1
`define KP_BIT_SENSE           0
`define KP_PIN_ENABLE_RESET    8'h00
`define KP_VECTOR_HIGH_ADDR    16'hFFDE
`define KP_VECTOR_LOW_ADDR     16'hFFDF
`endif

// ==== rtl/pin_sync.v ====
`timescale 1ns/1ps
// Two-stage synchroniser for a pin bus; resets to idle-high
module pin_sync #(
  parameter WIDTH = 8
) (
  input  wire             sys_clk_in,
  input  wire             rst_b_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;

  // First stage feeds only the second
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      stage1_reg <= {WIDTH{1'b1}};
      stage2_reg <= {WIDTH{1'b1}};
    end else begin
      stage1_reg <= async_in;
      stage2_reg <= stage1_reg;
    end
  end

  assign sync_out = stage2_reg;
endmodule

// ==== rtl/keypad_pin_interrupt.v ====
`timescale 1ns/1ps
`include "keypad_defs.vh"
module keypad_pin_interrupt (
  input  wire        sys_clk_in,
  input  wire        rst_b_in,
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output reg  [31:0] prdata_out,
  output wire        pready_out,
  output wire        pslverr_out,
  input  wire [3:0]  port_a_pin_in,
  input  wire [7:4]  port_d_pin_in,
  input  wire [3:0]  port_a_dir_in,
  input  wire [7:4]  port_d_dir_in,
  output wire [3:0]  port_a_dir_eff_out,
  output wire [7:4]  port_d_dir_eff_out,
  output wire [7:0]  pullup_en_out,
  input  wire        vector_fetch_in,
  input  wire        break_state_in,
  input  wire        break_clear_enable_in,
  output wire        irq_out,
  output wire        wake_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg  [7:0] pin_enable_bits_reg;
  reg        mask_bit_reg;
  reg        sensitivity_select_reg;
  reg        latch_reg;
  reg        latch_next;
  reg        any_low_prev_reg;
  reg        acked_reg;
  reg        acked_next;
  wire [7:0] pins_raw;
  wire [7:0] pins_sync;
  wire       any_low;
  wire       new_fall;
  wire       ack_write;
  wire       ack_pulse;
  wire       wr_en;
  wire       rd_en;
  wire       hit_sc;
  wire       hit_pe;

  // Map port pins to keypad input numbers
  assign pins_raw = {port_d_pin_in, port_a_pin_in};

  pin_sync #(
    .WIDTH (8)
  ) pin_sync_inst (
    .sys_clk_in (sys_clk_in),
    .rst_b_in   (rst_b_in),
    .async_in   (pins_raw),
    .sync_out   (pins_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Pin control outputs
  assign pullup_en_out = pin_enable_bits_reg;
  // Enabled pin forced to input (0) whatever the direction register says
  assign port_a_dir_eff_out = port_a_dir_in & ~pin_enable_bits_reg[3:0];
  assign port_d_dir_eff_out = port_d_dir_in & ~pin_enable_bits_reg[7:4];

  ////////////////////////////////////////////////////////////////////////////
  // APB decode; zero wait states, unmapped reads give zero and error
  assign hit_sc      = (paddr_in == `KP_STATUS_CONTROL_ADDR);
  assign hit_pe      = (paddr_in == `KP_PIN_ENABLE_ADDR);
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~(hit_sc | hit_pe);
  assign wr_en       = psel_in & penable_in & pwrite_in;
  assign rd_en       = psel_in & ~penable_in & ~pwrite_in;

  // Software acknowledge is a single cycle pulse, stored only as a level-mode ack while a pin is low
  assign ack_write = wr_en & hit_sc & pwdata_in[`KP_BIT_ACK];
  // Break protection gates only software acknowledge
  assign ack_pulse = (ack_write & (~break_state_in | break_clear_enable_in))
                   | vector_fetch_in;

  ////////////////////////////////////////////////////////////////////////////
  // Edge and level detection on enabled pins
  assign any_low  = |(~pins_sync & pin_enable_bits_reg);
  // Falling only counts when every enabled pin was high before
  assign new_fall = any_low & ~any_low_prev_reg;

  // Request latch; a level-mode acknowledge seen while a pin is low is
  // remembered, so ack and release may come in either order
  always @* begin
    latch_next = latch_reg;
    acked_next = acked_reg;
    if (ack_pulse) begin
      if (sensitivity_select_reg && any_low) begin
        acked_next = 1'b1;
      end else begin
        latch_next = 1'b0;
        acked_next = 1'b0;
      end
    end
    // Both events seen: clear once every enabled pin is high
    if (sensitivity_select_reg && acked_reg && !any_low) begin
      latch_next = 1'b0;
      acked_next = 1'b0;
    end
    // Set beats acknowledge in the same cycle
    if (new_fall) begin
      latch_next = 1'b1;
      acked_next = 1'b0;
    end
  end

  // Control state
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      latch_reg              <= 1'b0;
      sensitivity_select_reg <= 1'b0;
      mask_bit_reg           <= 1'b0;
      pin_enable_bits_reg    <= `KP_PIN_ENABLE_RESET;
      any_low_prev_reg       <= 1'b0;
      acked_reg              <= 1'b0;
    end else begin
      latch_reg        <= latch_next;
      any_low_prev_reg <= any_low;
      acked_reg        <= acked_next;
      if (wr_en && hit_sc) begin
        mask_bit_reg           <= pwdata_in[`KP_BIT_MASK];
        sensitivity_select_reg <= pwdata_in[`KP_BIT_SENSE];
      end
      if (wr_en && hit_pe) begin
        pin_enable_bits_reg <= pwdata_in[7:0];
      end
    end
  end

  // Read data captured in setup so it stands during access
  always @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      prdata_out <= 32'h00000000;
    end else if (rd_en) begin
      if (hit_sc) begin
        prdata_out <= {28'h0000000, latch_reg, 1'b0, mask_bit_reg,
                       sensitivity_select_reg};
      end else if (hit_pe) begin
        prdata_out <= {24'h000000, pin_enable_bits_reg};
      end else begin
        prdata_out <= 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Request and wake
  // CPU fetches the vector at the FFDE/FFDF pair when unmasked
  assign irq_out  = latch_reg & ~mask_bit_reg;
  // Wake taken straight from pins so it works with the clock stopped
  assign wake_out = ~mask_bit_reg & (irq_out | |(~pins_raw & pin_enable_bits_reg));

endmodule

// ==== testbench/keypad_pin_interrupt_assertions.sv ====
`timescale 1ns/1ps
module keypad_pin_interrupt_assertions (
  input logic        sys_clk_in,
  input logic        rst_b_in,
  input logic        psel_in,
  input logic        penable_in,
  input logic        pwrite_in,
  input logic [11:0] paddr_in,
  input logic [31:0] pwdata_in,
  input logic [31:0] prdata_out,
  input logic        pready_out,
  input logic        pslverr_out,
  input logic [3:0]  port_a_pin_in,
  input logic [7:4]  port_d_pin_in,
  input logic [7:0]  pullup_en_out,
  input logic        irq_out,
  input logic        wake_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  // Access phase and the two register writes
  wire acc = psel_in & penable_in;
  wire ws  = acc & pwrite_in & (paddr_in == 12'h0);
  wire we  = acc & pwrite_in & (paddr_in == 12'h4);
  a_ready_now: assert property (acc |-> pready_out) else $error("pready low");
  a_err_idle: assert property (!acc |-> !pslverr_out) else $error("slverr idle");
  a_err_unmapped: assert property (acc |-> pslverr_out == !(paddr_in inside {12'h0, 12'h4}))
    else $error("slverr");
  a_reset_idle: assert property ($rose(rst_b_in) |-> !irq_out && !pullup_en_out)
    else $error("reset");
  a_irq_wakes: assert property (irq_out |-> wake_out) else $error("wake");
  // Wake without a request only while an enabled pin is low
  a_wake_pins: assert property (wake_out && !irq_out |->
    |(~{port_d_pin_in, port_a_pin_in} & pullup_en_out)) else $error("wake pins");
  a_ack_reads_0: assert property (psel_in && !penable_in && !pwrite_in && paddr_in == 12'h0
    |=> !prdata_out[2]) else $error("ack read");
  a_enable_rw: assert property (we |=> pullup_en_out == $past(pwdata_in[7:0]))
    else $error("enable");
  a_mask_hides: assert property (ws && pwdata_in[1] |=> !irq_out) else $error("mask");
endmodule
bind keypad_pin_interrupt keypad_pin_interrupt_assertions
  checker_inst (.*);

// ==== testbench/keypad_switches.sv ====
`timescale 1ns/1ps
// Keys short to ground; unpulled open lines wander
module keypad_switches (
  input  logic       clk_in,
  input  logic [7:0] press_in,
  input  logic [7:0] pullup_in,
  output logic [7:0] pin_out
);
  logic [7:0] drift_reg = 8'h55;
  always @(posedge clk_in) drift_reg <= ~drift_reg;
  assign pin_out = ~press_in & (pullup_in | drift_reg);
endmodule

// ==== testbench/keypad_pin_interrupt_bench.sv ====
`timescale 1ns/1ps
module keypad_pin_interrupt_bench;
  logic        clk = 0, rst_b_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, err;
  logic        vector_fetch_in = 0, break_state_in = 0, break_clear_enable_in = 0;
  logic        pready_out, pslverr_out, irq_out, wake_out, lt = 0, mk = 0, md = 0;
  logic [11:0] paddr_in = 12'h0;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [3:0]  port_a_pin_in, port_a_dir_in = 4'h0, port_a_dir_eff_out;
  logic [7:4]  port_d_pin_in, port_d_dir_in = 4'h0, port_d_dir_eff_out;
  logic [7:0]  press = 8'h0, pullup_en_out, en, pins, pe = 8'h0;
  int          err_total = 0, comparisons = 0, cyc = 0;
  keypad_switches keypad_switches_inst (.clk_in(clk), .press_in(press),
    .pullup_in(pullup_en_out), .pin_out(pins));
  // Switch model feeds both port halves
  assign {port_d_pin_in, port_a_pin_in} = pins;
  keypad_pin_interrupt keypad_pin_interrupt_inst (.*, .sys_clk_in(clk));
  always #25 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  // Request held until pready is seen
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
    @(posedge clk);
    penable_in <= 1'b1;
    @(posedge clk);
    while (pready_out !== 1'b1) @(posedge clk);
    {rd, err} = {prdata_out, pslverr_out};
    {psel_in, penable_in} <= 2'b00;
  endtask
  // Status write; model takes the latch the rules predict
  task st(input logic [31:0] d, input logic l);
    apb(1'b1, 12'h0, d);
    {lt, mk, md} = {l, d[1], d[0]};
  endtask
  // Synchroniser delay passes, then irq and status against the model
  task settle(input string n);
    repeat (5) @(posedge clk);
    chk(n, lt & ~mk, irq_out);
    chk({n, " wake"}, ~mk & (lt | (|(press & pe))), wake_out);
    chk({n, " pullup"}, pe, pullup_en_out);
    chk({n, " dir"}, {port_d_dir_in, port_a_dir_in} & ~pe,
      {port_d_dir_eff_out, port_a_dir_eff_out});
    apb(1'b0, 12'h0, 32'h0);
    chk(n, {lt, 1'b0, mk, md}, rd);
    $display("done %s", n);
  endtask
  initial begin
    void'($urandom(32'h17F56D85));
    en = 8'($urandom) | 8'h81;
    repeat (10) @(posedge clk);
    rst_b_in <= 1'b1;
    {port_d_dir_in, port_a_dir_in} <= 8'($urandom);
    settle("reset");
    apb(1'b0, 12'h4, 32'h0);
    chk("enable", 32'h0, rd);
    st(32'h2, 1'b0);
    apb(1'b1, 12'h4, en);
    pe = en;
    apb(1'b0, 12'h4, 32'h0);
    chk("enable", en, rd);
    st(32'h4, 1'b0);
    settle("idle");
    press <= 8'h01;
    lt = 1;
    settle("edge");
    st(32'h2, 1'b1);
    settle("masked");
    st(32'h4, 1'b0);
    press <= 8'h81;
    settle("second low");
    press <= ~en;
    settle("disabled");
    press <= 8'h80;
    lt = 1;
    settle("fresh");
    vector_fetch_in <= 1'b1;
    @(posedge clk);
    vector_fetch_in <= 1'b0;
    lt = 0;
    settle("fetch");
    press <= 8'h00;
    st(32'h1, 1'b0);
    press <= 8'h01;
    lt = 1;
    settle("level");
    st(32'h5, 1'b1);
    settle("level ack");
    press <= 8'h00;
    lt = 0;
    settle("release");
    st(32'h0, 1'b1);
    {break_state_in, press} <= {1'b1, 8'h01};
    settle("break");
    st(32'h4, 1'b1);
    settle("protected");
    break_clear_enable_in <= 1'b1;
    st(32'h4, 1'b0);
    settle("cleared");
    {break_state_in, press} <= {1'b0, 8'h00};
    settle("break exit");
    apb(1'b0, 12'h8, 32'h0);
    chk("slverr", 32'h1, err);
    chk("unmapped", 32'h0, rd);
    st(32'h3, 1'b1);
    press <= 8'h01;
    settle("held");
    rst_b_in <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b_in <= 1'b1;
    {lt, mk, md, pe} = 11'h000;
    settle("second reset");
    apb(1'b0, 12'h4, 32'h0);
    chk("enable", 32'h0, rd);
    tally_and_finish;
  end
endmodule
